/* common/bus_cycle_pkg.sv */
package bus_cycle_pkg;

	// ************************************************************
	// Cycle status codes seen by an external bus controller
	// ************************************************************
	localparam logic [2:0] STAT_INTERRUPT_ACK_STROBE    = 3'h0;
	localparam logic [2:0] STAT_IO_RD   = 3'h1;
	localparam logic [2:0] STAT_IO_WR   = 3'h2;
	localparam logic [2:0] STAT_HALT    = 3'h3;
	localparam logic [2:0] STAT_CODE    = 3'h4;
	localparam logic [2:0] STAT_MEM_RD  = 3'h5;
	localparam logic [2:0] STAT_MEM_WR  = 3'h6;
	localparam logic [2:0] STAT_PASSIVE = 3'h7;

	// ************************************************************
	// Timing and reset values
	// ************************************************************
	// Each T state lasts two system clocks: first half, second half
	localparam int          CLOCKS_PER_T = 2;
	localparam logic [19:0] ADDR_RESET   = 20'h00000;
	localparam logic [15:0] DATA_RESET   = 16'h0000;
	localparam logic [9:0]  VECTOR_RESET = 10'h000;
	// Strap flops reset to minimum mode, else the first cycle runs in maximum mode
	localparam logic [18:0] SYNC_RESET   = 19'h20000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_T1   = 3'b001,
		ST_T2   = 3'b010,
		ST_T3   = 3'b011,
		ST_TW   = 3'b100,
		ST_T4   = 3'b101
	} state_type;

	typedef enum logic [2:0]
	{
		CY_CODE  = 3'b000,
		CY_READ  = 3'b001,
		CY_WRITE = 3'b010,
		CY_INTERRUPT_ACK_STROBE  = 3'b011,
		CY_HALT  = 3'b100
	} cycle_type;

endpackage : bus_cycle_pkg

/* hdl/bus_cycle_unit.sv */
module bus_cycle_unit
(
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_resetn,
	input  wire logic                    i_req,
	input  wire bus_cycle_pkg::cycle_type i_cycle,
	input  wire logic                    i_is_io,
	input  wire logic                    i_word,
	input  wire logic [19:0]             i_addr,
	input  wire logic [15:0]             i_wdata,
	output logic                         o_req_ready,
	output logic                         o_done,
	output logic [15:0]                  o_rdata,
	output logic [9:0]                   o_vector_ptr,
	input  wire logic [15:0]             i_ad_in,
	output logic [15:0]                  o_ad_out,
	output logic                         o_ad_oe,
	output logic [3:0]                   o_addr_hi,
	output logic                         o_addr_latch_strobe,
	output logic                         o_mem_io,
	output logic                         o_read_strobe_n,
	output logic                         o_write_strobe_n,
	output logic                         o_interrupt_ack_strobe_n,
	output logic                         o_transceiver_direction,
	output logic                         o_transceiver_output_enable_n,
	output logic                         o_upper_lane_enable_n,
	output logic                         o_cycle_type_bit_two,
	output logic                         o_cycle_type_bit_one,
	output logic                         o_cycle_type_bit_zero,
	output logic                         o_lock_n,
	input  wire logic                    i_bus_style_strap,
	input  wire logic                    i_ready,
	input  wire logic                    i_hold_req,
	output logic                         o_hold_ack
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [18:0] sync1_q;
	logic [18:0] sync2_q;
	logic [15:0] ad_s;
	logic        ready_s;
	logic        strap_s;
	logic        hold_s;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync1_q <= bus_cycle_pkg::SYNC_RESET;
			sync2_q <= bus_cycle_pkg::SYNC_RESET;
		end
		else
		begin
			sync1_q <= {i_hold_req, i_bus_style_strap, i_ready, i_ad_in};
			sync2_q <= sync1_q;
		end
	end

	assign ad_s    = sync2_q[15:0];
	assign ready_s = sync2_q[16];
	assign strap_s = sync2_q[17];
	assign hold_s  = sync2_q[18];

	// ************************************************************
	// Cycle sequencer
	// ************************************************************
	bus_cycle_pkg::state_type state_q, state_d;
	bus_cycle_pkg::cycle_type kind_q, kind_d;
	logic        half_q, half_d;
	logic        second_q, second_d;
	logic        lock_q, lock_d;
	logic        max_q, max_d;
	logic        io_q, io_d;
	logic        word_q, word_d;
	logic        done_q, done_d;
	logic        hold_q, hold_d;
	logic [19:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [15:0] rdata_q, rdata_d;
	logic [9:0]  vec_q, vec_d;
	logic        accept;
	logic        step;

	assign accept = i_req && o_req_ready;
	assign step   = half_q;

	always_comb
	begin
		state_d  = state_q;
		kind_d   = kind_q;
		half_d   = (state_q == bus_cycle_pkg::ST_IDLE) ? 1'b0 : ~half_q;
		second_d = second_q;
		lock_d   = lock_q;
		max_d    = max_q;
		io_d     = io_q;
		word_d   = word_q;
		done_d   = 1'b0;
		hold_d   = 1'b0;
		addr_d   = addr_q;
		wdata_d  = wdata_q;
		rdata_d  = rdata_q;
		vec_d    = vec_q;
		unique case (state_q)
			bus_cycle_pkg::ST_IDLE:
			begin
				// Strap is static; follow it only between cycles
				max_d  = !strap_s;
				// Pair never passes through idle, so no grant inside it
				hold_d = hold_s && !i_req;
				if (accept)
				begin
					state_d  = bus_cycle_pkg::ST_T1;
					kind_d   = i_cycle;
					io_d     = i_is_io;
					word_d   = i_word;
					addr_d   = i_addr;
					wdata_d  = i_wdata;
					second_d = 1'b0;
				end
			end
			bus_cycle_pkg::ST_T1:
				if (step)
				begin
					if (kind_q == bus_cycle_pkg::CY_HALT)
					begin
						state_d = bus_cycle_pkg::ST_IDLE;
						done_d  = 1'b1;
					end
					else
					begin
						state_d = bus_cycle_pkg::ST_T2;
					end
				end
			bus_cycle_pkg::ST_T2:
			begin
				if (!half_q && kind_q == bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE)
				begin
					lock_d = !second_q;
				end
				if (step)
				begin
					state_d = bus_cycle_pkg::ST_T3;
				end
			end
			bus_cycle_pkg::ST_T3, bus_cycle_pkg::ST_TW:
				if (step)
				begin
					state_d = ready_s ? bus_cycle_pkg::ST_T4 : bus_cycle_pkg::ST_TW;
				end
			bus_cycle_pkg::ST_T4:
				if (step)
				begin
					if (kind_q == bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE && !second_q)
					begin
						state_d  = bus_cycle_pkg::ST_T1;
						second_d = 1'b1;
					end
					else
					begin
						state_d  = bus_cycle_pkg::ST_IDLE;
						second_d = 1'b0;
						done_d   = 1'b1;
						if (kind_q == bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE)
						begin
							rdata_d = {8'h00, ad_s[7:0]};
							vec_d   = {ad_s[7:0], 2'b00};
						end
						else if (word_q)
						begin
							rdata_d = ad_s;
						end
						else
						begin
							rdata_d = {8'h00, addr_q[0] ? ad_s[15:8] : ad_s[7:0]};
						end
					end
				end
			default:
				state_d = bus_cycle_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_q  <= bus_cycle_pkg::ST_IDLE;
			kind_q   <= bus_cycle_pkg::CY_CODE;
			half_q   <= 1'b0;
			second_q <= 1'b0;
			lock_q   <= 1'b0;
			max_q    <= 1'b0;
			io_q     <= 1'b0;
			word_q   <= 1'b0;
			done_q   <= 1'b0;
			hold_q   <= 1'b0;
			addr_q   <= bus_cycle_pkg::ADDR_RESET;
			wdata_q  <= bus_cycle_pkg::DATA_RESET;
			rdata_q  <= bus_cycle_pkg::DATA_RESET;
			vec_q    <= bus_cycle_pkg::VECTOR_RESET;
		end
		else
		begin
			state_q  <= state_d;
			kind_q   <= kind_d;
			half_q   <= half_d;
			second_q <= second_d;
			lock_q   <= lock_d;
			max_q    <= max_d;
			io_q     <= io_d;
			word_q   <= word_d;
			done_q   <= done_d;
			hold_q   <= hold_d;
			addr_q   <= addr_d;
			wdata_q  <= wdata_d;
			rdata_q  <= rdata_d;
			vec_q    <= vec_d;
		end
	end

	// ************************************************************
	// Pin decode
	// ************************************************************
	logic in_t1, in_t2, in_t34, busy, rd_kind, wr_kind, ack_kind;

	assign in_t1    = state_q == bus_cycle_pkg::ST_T1;
	assign in_t2    = state_q == bus_cycle_pkg::ST_T2;
	assign in_t34   = state_q == bus_cycle_pkg::ST_T3 || state_q == bus_cycle_pkg::ST_TW;
	assign busy     = state_q != bus_cycle_pkg::ST_IDLE;
	assign rd_kind  = kind_q == bus_cycle_pkg::CY_READ || kind_q == bus_cycle_pkg::CY_CODE;
	assign wr_kind  = kind_q == bus_cycle_pkg::CY_WRITE;
	assign ack_kind = kind_q == bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE;

	assign o_req_ready  = !busy && !hold_q;
	assign o_done       = done_q;
	assign o_rdata      = rdata_q;
	assign o_vector_ptr = vec_q;
	assign o_hold_ack   = hold_q;
	assign o_addr_hi    = addr_q[19:16];
	assign o_mem_io     = !io_q;

	// Ack cycles leave the lines to the bus keepers
	assign o_ad_oe  = (in_t1 && !ack_kind) || (wr_kind && busy && !in_t1);
	assign o_ad_out = in_t1 ? addr_q[15:0]
		: (!word_q && addr_q[0]) ? {wdata_q[7:0], 8'h00} : wdata_q;
	assign o_upper_lane_enable_n = !(word_q || addr_q[0]);

	// Address strobe in first half of T1; max mode leaves it to the controller
	assign o_addr_latch_strobe = !max_q && in_t1 && !half_q;
	// Read type strobes wait half a T state so address drivers can turn off
	assign o_read_strobe_n          = !(!max_q && rd_kind && ((in_t2 && half_q) || in_t34));
	assign o_interrupt_ack_strobe_n = !(!max_q && ack_kind && ((in_t2 && half_q) || in_t34));
	assign o_write_strobe_n         = !(!max_q && wr_kind && (in_t2 || in_t34));
	assign o_transceiver_direction  = wr_kind && busy;
	assign o_transceiver_output_enable_n =
		!((in_t2 || in_t34 || (state_q == bus_cycle_pkg::ST_T4 && !half_q)) && kind_q != bus_cycle_pkg::CY_HALT);
	assign o_lock_n = !(max_q && lock_q);

	logic [2:0] stat;

	always_comb
	begin
		stat = bus_cycle_pkg::STAT_PASSIVE;
		if (max_q && (in_t1 || in_t2 || in_t34))
		begin
			unique case (kind_q)
				bus_cycle_pkg::CY_CODE:  stat = bus_cycle_pkg::STAT_CODE;
				bus_cycle_pkg::CY_READ:  stat = io_q ? bus_cycle_pkg::STAT_IO_RD : bus_cycle_pkg::STAT_MEM_RD;
				bus_cycle_pkg::CY_WRITE: stat = io_q ? bus_cycle_pkg::STAT_IO_WR : bus_cycle_pkg::STAT_MEM_WR;
				bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE:  stat = bus_cycle_pkg::STAT_INTERRUPT_ACK_STROBE;
				bus_cycle_pkg::CY_HALT:  stat = bus_cycle_pkg::STAT_HALT;
				default:                 stat = bus_cycle_pkg::STAT_PASSIVE;
			endcase
		end
	end

	assign {o_cycle_type_bit_two, o_cycle_type_bit_one, o_cycle_type_bit_zero} = stat;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	sequence first_ack_end;
		state_q == bus_cycle_pkg::ST_T4 && half_q && ack_kind && !second_q;
	endsequence
	sequence second_ack_start;
		in_t1 && second_q && !half_q;
	endsequence

	a_min_no_status: assert property (!max_q |-> stat == bus_cycle_pkg::STAT_PASSIVE)
		else $error("status driven in minimum mode");
	a_max_no_strobes: assert property (max_q |-> o_read_strobe_n && o_write_strobe_n && !o_addr_latch_strobe)
		else $error("strobe driven in maximum mode");
	a_ale_with_addr: assert property (o_addr_latch_strobe && !ack_kind |-> in_t1 && o_ad_oe && o_ad_out == addr_q[15:0])
		else $error("address strobe without address");
	a_read_late: assert property ($fell(o_read_strobe_n) |-> in_t2 && half_q && !o_ad_oe && $past(in_t2))
		else $error("read strobe timing wrong");
	a_write_t2: assert property (in_t2 && !half_q && wr_kind && !max_q |-> !o_write_strobe_n [*2] ##1 !o_write_strobe_n)
		else $error("write strobe not held from T2");
	a_ack_pair: assert property (first_ack_end |=> second_ack_start)
		else $error("second acknowledge missing");
	a_vector_times_four: assert property ($rose(o_done) && ack_kind |-> o_vector_ptr == {o_rdata[7:0], 2'b00})
		else $error("vector pointer wrong");
	a_hold_no_pair: assert property (o_hold_ack |-> !busy && !second_q)
		else $error("hold granted inside cycle");
	a_lock_span: assert property (second_ack_start |-> lock_q ##2 lock_q ##2 !lock_q)
		else $error("lock span wrong");
	a_wait_ready: assert property (in_t34 && half_q && !ready_s |=> state_q == bus_cycle_pkg::ST_TW)
		else $error("wait state missing");
	a_halt_one_ale: assert property (in_t1 && !half_q && kind_q == bus_cycle_pkg::CY_HALT |-> o_read_strobe_n
		&& o_write_strobe_n && o_interrupt_ack_strobe_n ##1 o_read_strobe_n && o_write_strobe_n
		&& o_interrupt_ack_strobe_n && !o_addr_latch_strobe ##1 !busy)
		else $error("halt cycle wrong");

endmodule : bus_cycle_unit

/* verif/bus_cycle_unit_tb.sv */
module bus_cycle_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                     i_sys_clk = 1'b0;
	logic                     o_req_ready, o_done, o_ad_oe, o_addr_latch_strobe, o_mem_io;
	logic                     o_read_strobe_n, o_write_strobe_n, o_interrupt_ack_strobe_n, o_lock_n, o_hold_ack;
	logic                     o_transceiver_direction, o_transceiver_output_enable_n, o_upper_lane_enable_n;
	logic                     o_cycle_type_bit_two, o_cycle_type_bit_one, o_cycle_type_bit_zero, m_oe, exp_mem;
	logic                     i_resetn = 1'b0, i_req = 1'b0, i_is_io = 1'b0, i_word = 1'b0, busy = 1'b0;
	logic                     i_bus_style_strap = 1'b1, i_hold_req = 1'b0, i_ready;
	bus_cycle_pkg::cycle_type i_cycle = bus_cycle_pkg::CY_CODE;
	logic [19:0]              i_addr = 20'h00000;
	logic [15:0]              i_wdata = 16'h0000, hold_q = 16'h0000;
	logic [15:0]              i_ad_in, o_rdata, o_ad_out, m_data, m_addr, m_wdata;
	logic [9:0]               o_vector_ptr;
	logic [3:0]               o_addr_hi, waits = 4'h0;
	logic [7:0]               itype = 8'h2D;
	logic [4:0]               lane;
	logic [2:0]               stat;
	int                       errors, checks_done, n, lo_rd, lo_wr, lo_ack, n_ale, n_lock, hold_early, viol;

	bus_cycle_unit bus_cycle_unit_inst
	(
		.i_sys_clk (i_sys_clk), .i_resetn (i_resetn), .i_req (i_req), .i_cycle (i_cycle), .i_is_io (i_is_io),
		.i_word (i_word), .i_addr (i_addr), .i_wdata (i_wdata), .o_req_ready (o_req_ready), .o_done (o_done),
		.o_rdata (o_rdata), .o_vector_ptr (o_vector_ptr), .i_ad_in (i_ad_in), .o_ad_out (o_ad_out),
		.o_ad_oe (o_ad_oe), .o_addr_hi (o_addr_hi), .o_addr_latch_strobe (o_addr_latch_strobe),
		.o_mem_io (o_mem_io), .o_read_strobe_n (o_read_strobe_n), .o_write_strobe_n (o_write_strobe_n),
		.o_interrupt_ack_strobe_n (o_interrupt_ack_strobe_n), .o_transceiver_direction (o_transceiver_direction),
		.o_transceiver_output_enable_n (o_transceiver_output_enable_n),
		.o_upper_lane_enable_n (o_upper_lane_enable_n), .o_cycle_type_bit_two (o_cycle_type_bit_two),
		.o_cycle_type_bit_one (o_cycle_type_bit_one), .o_cycle_type_bit_zero (o_cycle_type_bit_zero),
		.o_lock_n (o_lock_n), .i_bus_style_strap (i_bus_style_strap), .i_ready (i_ready),
		.i_hold_req (i_hold_req), .o_hold_ack (o_hold_ack)
	);

	bus_target_model bus_target_model_inst
	(
		.i_sys_clk (i_sys_clk), .i_resetn (i_resetn), .i_bus (i_ad_in), .i_latch (o_addr_latch_strobe),
		.i_read_n (o_read_strobe_n), .i_write_n (o_write_strobe_n), .i_ack_n (o_interrupt_ack_strobe_n),
		.i_waits (waits), .i_type (itype), .o_oe (m_oe), .o_data (m_data), .o_ready (i_ready),
		.o_addr_q (m_addr), .o_wdata_q (m_wdata)
	);

	// Released lines keep their last level through the bus keepers
	assign i_ad_in = o_ad_oe ? o_ad_out : (m_oe ? m_data : hold_q);

	// ************************************************************
	// Bus monitor
	// ************************************************************
	always @(posedge i_sys_clk)
	begin
		hold_q <= i_ad_in;
		lo_rd += !o_read_strobe_n;
		lo_wr += !o_write_strobe_n;
		lo_ack += !o_interrupt_ack_strobe_n;
		n_lock += !o_lock_n;
		n_ale += o_addr_latch_strobe;
		hold_early += busy && o_hold_ack;
		if (o_addr_latch_strobe)
			lane = {o_addr_hi, o_upper_lane_enable_n};
		if ({o_cycle_type_bit_two, o_cycle_type_bit_one, o_cycle_type_bit_zero} !== bus_cycle_pkg::STAT_PASSIVE)
			stat = {o_cycle_type_bit_two, o_cycle_type_bit_one, o_cycle_type_bit_zero};
		if ((!o_read_strobe_n && (o_ad_oe || o_mem_io !== exp_mem || o_transceiver_direction
			|| o_transceiver_output_enable_n)) || (!o_write_strobe_n && (!o_ad_oe || o_mem_io !== exp_mem
			|| !o_transceiver_direction)) || (!o_interrupt_ack_strobe_n && o_ad_oe))
			viol++;
	end

	initial
	begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	task automatic run(input bus_cycle_pkg::cycle_type cy, input logic io, input logic wd, input logic [19:0] a,
		input logic [15:0] d, input logic hold);
		@(negedge i_sys_clk);
		while (!o_req_ready)
			@(negedge i_sys_clk);
		{n, lo_rd, lo_wr, lo_ack, n_ale, n_lock, hold_early, viol} = '0;
		stat = bus_cycle_pkg::STAT_PASSIVE;
		exp_mem = !io;
		i_req = 1'b1;
		i_cycle = cy;
		{i_is_io, i_word, i_addr, i_wdata, i_hold_req} = {io, wd, a, d, hold};
		busy = 1'b1;
		@(negedge i_sys_clk);
		i_req = 1'b0;
		do
		begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		while (o_done !== 1'b1 && n < 300);
		busy = 1'b0;
		chk(o_done, 1'b1);
		chk(viol, 0);
		chk(hold_early, 0);
	endtask : run

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reads;
		run(bus_cycle_pkg::CY_READ, 1'b0, 1'b1, 20'h31234, 16'h0000, 1'b0);
		chk(n, 8);
		chk(m_addr, 16'h1234);
		chk(o_rdata, 16'hCB34);
		chk(lane, 5'h06);
		chk(lo_rd, 3);
		chk(lo_wr + lo_ack, 0);
		waits = 4'h3;
		run(bus_cycle_pkg::CY_READ, 1'b1, 1'b0, 20'h00057, 16'h0000, 1'b0);
		chk(n, 12);
		chk(lo_rd, 7);
		chk(o_rdata, 16'h00A8);
		chk(lane, 5'h00);
	endtask : t_reads

	task automatic t_writes;
		waits = 4'h0;
		run(bus_cycle_pkg::CY_WRITE, 1'b0, 1'b1, 20'h00100, 16'hBEEF, 1'b0);
		chk(m_wdata, 16'hBEEF);
		chk(lo_wr, 4);
		chk(lo_rd, 0);
		waits = 4'h2;
		run(bus_cycle_pkg::CY_WRITE, 1'b1, 1'b0, 20'h00A41, 16'h0096, 1'b0);
		chk(m_wdata[15:8], 8'h96);
		chk(lo_wr > 4, 1);
		chk(lane, 5'h00);
		run(bus_cycle_pkg::CY_WRITE, 1'b1, 1'b0, 20'h00A40, 16'h00C3, 1'b0);
		chk(m_wdata[7:0], 8'hC3);
		chk(lane, 5'h01);
	endtask : t_writes

	task automatic t_ack_pair;
		waits = 4'h0;
		run(bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE, 1'b0, 1'b0, 20'h00000, 16'h0000, 1'b1);
		chk(n, 16);
		chk(lo_rd, 0);
		chk(n_ale, 2);
		chk(o_rdata, 16'h002D);
		chk(o_vector_ptr, 10'h0B4);
		for (int k = 0; k < 10 && o_hold_ack !== 1'b1; k++)
			@(negedge i_sys_clk);
		chk(o_hold_ack, 1'b1);
		i_hold_req = 1'b0;
		run(bus_cycle_pkg::CY_HALT, 1'b0, 1'b0, 20'h00000, 16'h0000, 1'b0);
		chk(n, 2);
		chk(n_ale, 1);
		chk(lo_rd + lo_wr + lo_ack, 0);
	endtask : t_ack_pair

	task automatic t_max_mode;
		bus_cycle_pkg::cycle_type cy[7] = '{bus_cycle_pkg::CY_READ, bus_cycle_pkg::CY_READ, bus_cycle_pkg::CY_CODE,
			bus_cycle_pkg::CY_WRITE, bus_cycle_pkg::CY_WRITE, bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE, bus_cycle_pkg::CY_HALT};
		logic [2:0] st[7] = '{bus_cycle_pkg::STAT_MEM_RD, bus_cycle_pkg::STAT_IO_RD, bus_cycle_pkg::STAT_CODE,
			bus_cycle_pkg::STAT_MEM_WR, bus_cycle_pkg::STAT_IO_WR, bus_cycle_pkg::STAT_INTERRUPT_ACK_STROBE, bus_cycle_pkg::STAT_HALT};
		logic [6:0] io = 7'b0010010;
		@(negedge i_sys_clk);
		i_bus_style_strap = 1'b0;
		repeat (4) @(negedge i_sys_clk);
		for (int k = 0; k < 7; k++)
		begin
			run(cy[k], io[k], 1'b1, 20'h00200, 16'h5A5A, 1'b0);
			chk(stat, st[k]);
			chk(n_ale + lo_rd + lo_wr + lo_ack, 0);
			chk(n_lock, (cy[k] == bus_cycle_pkg::CY_INTERRUPT_ACK_STROBE) ? 8 : 0);
		end
	endtask : t_max_mode

	initial
	begin
		repeat (3) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		t_reads;
		t_writes;
		t_ack_pair;
		t_max_mode;
		summarize;
	end

	// Whole run needs under two hundred clocks
	initial
	begin
		repeat (5000) @(posedge i_sys_clk);
		errors++;
		summarize;
	end
endmodule : bus_cycle_unit_tb

/* verif/bus_target_model.sv */
module bus_target_model
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic [15:0] i_bus,
	input  wire logic        i_latch,
	input  wire logic        i_read_n,
	input  wire logic        i_write_n,
	input  wire logic        i_ack_n,
	input  wire logic [3:0]  i_waits,
	input  wire logic [7:0]  i_type,
	output logic             o_oe,
	output logic [15:0]      o_data,
	output logic             o_ready,
	output logic [15:0]      o_addr_q,
	output logic [15:0]      o_wdata_q
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] wait_q;
	logic       first_q;

	// Address is still valid on the lines at the strobe's falling edge
	always @(negedge i_latch)
		o_addr_q <= i_bus;

	always @(posedge i_write_n)
		o_wdata_q <= i_bus;

	// The controller stays silent in the first acknowledge
	always @(negedge i_ack_n or negedge i_resetn)
		first_q <= i_resetn ? !first_q : 1'b0;

	always @(negedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_oe    <= 1'b0;
			o_ready <= 1'b1;
			wait_q  <= 4'h0;
		end
		else if (!i_read_n || !i_write_n || !i_ack_n)
		begin
			o_oe    <= !i_read_n || (!i_ack_n && !first_q);
			o_data  <= i_read_n ? {~i_type, i_type} : {~o_addr_q[7:0], o_addr_q[7:0]};
			o_ready <= wait_q >= i_waits;
			wait_q  <= wait_q + {3'h0, wait_q < i_waits};
		end
		else
		begin
			o_oe    <= 1'b0;
			o_ready <= 1'b1;
			wait_q  <= 4'h0;
		end
	end
endmodule : bus_target_model
